// ==== design/tta_tlb_test.sv ====
`timescale 1ns/1ps
// Functional notes
// - cmd x00 writes first level, x01 writes second level, top bit ignored.
// - 010 read L1 X, 011 read L2 X, 110 read L1 Y; 111 taken as L2 Y.
// - first level entry index is linear address bits 15-12.
// - second level index is linear bits 17-12 plus way select.
// - hit flags and hit way are ignored during a write.
// - L1 read returns linear, attributes, physical, cache disable, write through.
// - L1 read sets hit flag bit 5 on hit, clears otherwise.
// - L2 read returns attributes, linear, physical and cache bits of entry.
// - L2 read sets hit bit 4; on hit reports way in bits 2-0.
// - way select in bits 9-7, legal values 0 to 5 only.
// - lookup updates other fields only when exactly one entry matches.
// - write sets entry valid from bit 11, else invalidates target.
// - physical register: page 31-12, cache disable 11, write through 10.
// - command register: linear 31-12, D10, G9, U8, W6, cmd 2-0.
// - first level 16 entries direct mapped; second level 384, six ways.
// - second level write invalidates the first level copy of the entry it replaces; first level writes do not touch level two.
module tta_tlb_test #(
    parameter int L1_N = 16,
    parameter int L2_S = 64
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o
);
    import tta_pkg::*;

    // ========================================================
    // entry storage
    // entry layout: valid, lin[19:0], phys[19:0], pcd, pwt, d, g, u, w, a
    localparam int EW = 48;
    logic [EW-1:0] l1_mem [L1_N];
    logic [EW-1:0] l2_mem [L2_S][L2_WAYS];
    logic [31:0] cmd_lin_q;
    logic [31:0] phys_stat_q;

    function automatic logic [EW-1:0] pack_entry(input logic [31:0] c,
            input logic [31:0] p);
        pack_entry = {c[VALID_BIT], c[31:LIN_LSB], p[31:PHYS_LSB],
            p[CACHE_DIS_BIT], p[WR_THRU_BIT], c[DIRTY_BIT], c[GLOBAL_BIT],
            c[USER_BIT], c[WRITE_BIT], c[ACCESSED_BIT]};
    endfunction

    function automatic logic ent_match(input logic [EW-1:0] e,
            input logic [19:0] lin);
        ent_match = e[47] && (e[46:27] == lin);
    endfunction

    // ========================================================
    // bus decode
    logic req;
    logic wr_cmd;
    logic wr_phys;
    logic hit_reg;
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign hit_reg = (wb_adr_i == OFS_CMD_LIN) || (wb_adr_i == OFS_PHYS_STAT);
    // writes land at the edge where the master samples ack high
    assign wr_cmd = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
        && (wb_adr_i == OFS_CMD_LIN);
    assign wr_phys = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o
        && (wb_adr_i == OFS_PHYS_STAT);

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] nw, input logic [3:0] sel);
        for (int i = 0; i < 4; i++) begin
            merge[8*i +: 8] = sel[i] ? nw[8*i +: 8] : old[8*i +: 8];
        end
    endfunction

    // ========================================================
    // command decode on the value being written
    logic [31:0] cmd_new;
    logic [2:0] cmd;
    logic [19:0] lin;
    logic [3:0] l1_idx;
    logic [5:0] l2_idx;
    logic [2:0] way_sel;
    logic way_ok;
    assign cmd_new = merge(cmd_lin_q, wb_dat_i, wb_sel_i);
    assign cmd = cmd_new[CMD_MSB:0];
    assign lin = cmd_new[31:LIN_LSB];
    assign l1_idx = lin[3:0];
    assign l2_idx = lin[5:0];
    assign way_sel = phys_stat_q[WAY_SEL_MSB:WAY_SEL_LSB];
    assign way_ok = way_sel <= L2_WAY_MAX;

    logic is_wr_l1;
    logic is_wr_l2;
    logic is_rd_l1;
    logic is_rd_l2;
    assign is_wr_l1 = wr_cmd && (cmd[1:0] == CMD_WR_L1);
    assign is_wr_l2 = wr_cmd && (cmd[1:0] == CMD_WR_L2) && way_ok;
    assign is_rd_l1 = wr_cmd
        && (cmd == CMD_RD_L1_X || cmd == CMD_RD_L1_Y);
    assign is_rd_l2 = wr_cmd
        && (cmd == CMD_RD_L2_X || cmd == CMD_RD_L2_Y);

    // ========================================================
    // lookups
    logic [EW-1:0] l1_ent;
    logic l1_hit;
    logic [2:0] l2_hit_cnt;
    logic [2:0] l2_hit_way;
    logic [EW-1:0] l2_hit_ent;
    assign l1_ent = l1_mem[l1_idx];
    assign l1_hit = ent_match(l1_ent, lin);

    always_comb begin
        l2_hit_cnt = 3'h0;
        l2_hit_way = 3'h0;
        l2_hit_ent = '0;
        for (int w = 0; w < L2_WAYS; w++) begin
            if (ent_match(l2_mem[l2_idx][w], lin)) begin
                l2_hit_cnt = l2_hit_cnt + 3'h1;
                l2_hit_way = w[2:0];
                l2_hit_ent = l2_mem[l2_idx][w];
            end
        end
    end

    // exactly one match required before fields are refreshed
    logic l2_one;
    assign l2_one = (l2_hit_cnt == 3'h1);

    // ========================================================
    // arrays: writes; a second level write drops the first level copy of the replaced entry
    logic [EW-1:0] wr_ent;
    assign wr_ent = pack_entry(cmd_new, phys_stat_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < L1_N; i++) begin
                l1_mem[i] <= '0;
            end
            for (int s = 0; s < L2_S; s++) begin
                for (int w = 0; w < L2_WAYS; w++) begin
                    l2_mem[s][w] <= '0;
                end
            end
        end else begin
            if (is_wr_l1) begin
                l1_mem[l1_idx] <= wr_ent;
            end
            if (is_wr_l2) begin
                l2_mem[l2_idx][way_sel] <= wr_ent;
                // drop the first level copy of the level two entry being overwritten
                if (ent_match(l2_mem[l2_idx][way_sel], l1_mem[lin[3:0]][46:27])
                        && ent_match(l1_mem[lin[3:0]],
                        l2_mem[l2_idx][way_sel][46:27])) begin
                    l1_mem[lin[3:0]][47] <= 1'b0;
                end
            end
        end
    end

    // ========================================================
    // command/linear register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_lin_q <= CMD_LIN_RESET;
        end else if (wr_cmd) begin
            cmd_lin_q <= cmd_new;
            if (is_rd_l1 && l1_hit) begin
                cmd_lin_q[31:LIN_LSB] <= l1_ent[46:27];
                cmd_lin_q[VALID_BIT] <= l1_ent[47];
                cmd_lin_q[DIRTY_BIT] <= l1_ent[4];
                cmd_lin_q[GLOBAL_BIT] <= l1_ent[3];
                cmd_lin_q[USER_BIT] <= l1_ent[2];
                cmd_lin_q[WRITE_BIT] <= l1_ent[1];
                cmd_lin_q[ACCESSED_BIT] <= l1_ent[0];
            end else if (is_rd_l2 && l2_one) begin
                cmd_lin_q[31:LIN_LSB] <= l2_hit_ent[46:27];
                cmd_lin_q[VALID_BIT] <= l2_hit_ent[47];
                cmd_lin_q[DIRTY_BIT] <= l2_hit_ent[4];
                cmd_lin_q[GLOBAL_BIT] <= l2_hit_ent[3];
                cmd_lin_q[USER_BIT] <= l2_hit_ent[2];
                cmd_lin_q[WRITE_BIT] <= l2_hit_ent[1];
                cmd_lin_q[ACCESSED_BIT] <= l2_hit_ent[0];
            end
        end
    end

    // ========================================================
    // physical/status register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            phys_stat_q <= PHYS_STAT_RESET;
        end else if (wr_phys) begin
            phys_stat_q <= merge(phys_stat_q, wb_dat_i, wb_sel_i);
        end else if (is_rd_l1) begin
            phys_stat_q[HIT1_BIT] <= l1_hit;
            if (l1_hit) begin
                phys_stat_q[31:PHYS_LSB] <= l1_ent[26:7];
                phys_stat_q[CACHE_DIS_BIT] <= l1_ent[6];
                phys_stat_q[WR_THRU_BIT] <= l1_ent[5];
            end
        end else if (is_rd_l2) begin
            phys_stat_q[HIT2_BIT] <= l2_one;
            if (l2_one) begin
                phys_stat_q[HIT_WAY_MSB:0] <= l2_hit_way;
                phys_stat_q[31:PHYS_LSB] <= l2_hit_ent[26:7];
                phys_stat_q[CACHE_DIS_BIT] <= l2_hit_ent[6];
                phys_stat_q[WR_THRU_BIT] <= l2_hit_ent[5];
            end
        end
        // tlb writes leave hit flags and hit way alone
    end

    // ========================================================
    // wishbone answer: one cycle after request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req && hit_reg;
            wb_err_o <= req && !hit_reg;
            if (req && !wb_we_i && wb_adr_i == OFS_CMD_LIN) begin
                wb_dat_o <= cmd_lin_q;
            end else if (req && !wb_we_i && wb_adr_i == OFS_PHYS_STAT) begin
                wb_dat_o <= phys_stat_q;
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end
endmodule // tta_tlb_test

// ==== design/tta_pkg.sv ====
package tta_pkg;
    // ========================================================
    // sizes
    localparam int L1_ENTRIES = 16;
    localparam int L2_SETS = 64;
    localparam int L2_WAYS = 6;
    localparam logic [2:0] L2_WAY_MAX = 3'h5;
    // ========================================================
    // register byte offsets (wishbone word aligned)
    localparam logic [3:0] OFS_CMD_LIN = 4'h0;
    localparam logic [3:0] OFS_PHYS_STAT = 4'h4;
    localparam logic [31:0] CMD_LIN_RESET = 32'h0000_0000;
    localparam logic [31:0] PHYS_STAT_RESET = 32'h0000_0000;
    // ========================================================
    // command/linear register fields
    localparam int LIN_LSB = 12;
    localparam int VALID_BIT = 11;
    localparam int DIRTY_BIT = 10;
    localparam int GLOBAL_BIT = 9;
    localparam int USER_BIT = 8;
    localparam int WRITE_BIT = 6;
    localparam int ACCESSED_BIT = 5;
    localparam int CMD_MSB = 2;
    // ========================================================
    // physical/status register fields
    localparam int PHYS_LSB = 12;
    localparam int CACHE_DIS_BIT = 11;
    localparam int WR_THRU_BIT = 10;
    localparam int WAY_SEL_MSB = 9;
    localparam int WAY_SEL_LSB = 7;
    localparam int HIT1_BIT = 5;
    localparam int HIT2_BIT = 4;
    localparam int HIT_WAY_MSB = 2;
    // ========================================================
    // commands
    localparam logic [1:0] CMD_WR_L1 = 2'h0;
    localparam logic [1:0] CMD_WR_L2 = 2'h1;
    localparam logic [2:0] CMD_RD_L1_X = 3'h2;
    localparam logic [2:0] CMD_RD_L2_X = 3'h3;
    localparam logic [2:0] CMD_RD_L1_Y = 3'h6;
    localparam logic [2:0] CMD_RD_L2_Y = 3'h7;
endpackage

// ==== testbench/tta_tlb_test_props.sv ====
`timescale 1ns/1ps
module tta_tlb_test_props (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic wb_err_o
);
    // ========================================
    // bus answer checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic mapped;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign mapped = (wb_adr_i == 4'h0) || (wb_adr_i == 4'h4);
    ack_mapped_a: assert property (take && mapped |=>
        wb_ack_o && !wb_err_o) else $error("mapped access not acknowledged");
    err_unmapped_a: assert property (take && !mapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    err_pulse_a: assert property (wb_err_o |=> $fell(wb_err_o))
        else $error("err longer than one cycle");
    ack_cause_a: assert property (wb_ack_o || wb_err_o |-> $past(take))
        else $error("answer without request");
    dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    rst_quiet_a: assert property (disable iff (1'b0) rst_i |=> !wb_ack_o
        && !wb_err_o) else $error("answer during reset");
    hit_way_a: assert property (wb_ack_o && $past(wb_adr_i) == 4'h4
        && !$past(wb_we_i) |-> wb_dat_o[2:0] <= 3'h5)
        else $error("hit way out of range");
endmodule // tta_tlb_test_props

// ==== testbench/test_tlb_test_access_port.sv ====
`timescale 1ns/1ps
module test_tlb_test_access_port;
    import tta_pkg::*;
    typedef struct packed {
        logic rd;
        logic err;
        logic [31:0] mask;
        logic [31:0] data;
    } tta_note_type;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o;
    logic [3:0] wb_adr_i;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, cmdv, phys, seed;
    logic [31:0] lins [6];
    logic [31:0] pgs [6];
    tta_note_type note_q[$];
    tta_note_type nt;
    int n_mismatch = 0;
    int checks_done = 0;
    tta_tlb_test DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o));
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ========================================
    // single classic wishbone cycle
    task automatic bus(input logic we, input logic [3:0] a,
        input logic [31:0] d, input logic [31:0] m, input logic [31:0] e);
        int n;
        note_q.push_back('{!we, a != 4'h0 && a != 4'h4, m, e});
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!(wb_ack_o || wb_err_o) && n < 50);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n >= 50) begin
            n_mismatch++;
            close_out();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 32'h0, 32'h0);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] m,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0, m, e);
    endtask
    // ========================================
    // answer monitor
    always @(posedge clk_i) begin
        if (!rst_i && (wb_ack_o || wb_err_o)) begin
            nt = note_q.pop_front();
            check("err", {31'h0, wb_err_o}, {31'h0, nt.err});
            if (nt.rd && !nt.err)
                check("rdata", wb_dat_o & nt.mask, nt.data & nt.mask);
        end
    end
    initial begin
        seed = 32'h0000_002F;
        {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'h8;
        wb_adr_i = 4'h0;
        wb_dat_i = 32'h0;
        wb_sel_i = 4'h0;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_CMD_LIN, 32'hFFFF_FFFF, CMD_LIN_RESET);
        rd(OFS_PHYS_STAT, 32'hFFFF_FFFF, PHYS_STAT_RESET);
        rd(4'h8, 32'h0, 32'h0);
        wr(4'hC, 32'hFFFF_FFFF);
        for (int k = 0; k < 2; k++) begin
            phys = rnd() & 32'hFFFF_FC00;
            cmdv = (rnd() & 32'hFFFF_0F60) | 32'h800 | (k << 12) | (k << 2);
            cmdv[15:12] = 4'(k + 1);
            wr(OFS_PHYS_STAT, phys);
            wr(OFS_CMD_LIN, cmdv);
            wr(OFS_PHYS_STAT, 32'h0);
            wr(OFS_CMD_LIN, (cmdv & 32'hFFFF_F000) | (k ? 3'h6 : 3'h2));
            rd(OFS_PHYS_STAT, 32'hFFFF_FC20, phys | 32'h20);
            rd(OFS_CMD_LIN, 32'hFFFF_FF60, cmdv);
            wr(OFS_CMD_LIN, ((cmdv ^ 32'h8000_0000) & 32'hFFFF_F000) | 3'h2);
            rd(OFS_PHYS_STAT, 32'h20, 32'h0);
        end
        for (int w = 0; w < 6; w++) begin
            lins[w] = (rnd() & 32'hFFFC_0000) | 32'h0002_A000;
            pgs[w] = rnd() & 32'hFFFF_FC00;
            wr(OFS_PHYS_STAT, pgs[w] | (w << 7));
            wr(OFS_CMD_LIN, lins[w] | 32'h800 | (w[0] ? 3'h5 : 3'h1));
        end
        wr(OFS_PHYS_STAT, (rnd() & 32'hFFFF_FC00) | (6 << 7));
        wr(OFS_CMD_LIN, lins[1] | 32'h800 | 3'h1);
        for (int w = 0; w < 6; w++) begin
            wr(OFS_PHYS_STAT, w << 7);
            wr(OFS_CMD_LIN, lins[w] | (w[0] ? 3'h7 : 3'h3));
            rd(OFS_PHYS_STAT, 32'hFFFF_FC17, pgs[w] | 32'h10 | w);
        end
        wr(OFS_PHYS_STAT, 32'h0);
        wr(OFS_CMD_LIN, lins[0] | 3'h1);
        wr(OFS_CMD_LIN, lins[0] | 3'h3);
        rd(OFS_PHYS_STAT, 32'h10, 32'h0);
        repeat (4) @(posedge clk_i);
        close_out();
    end
endmodule // test_tlb_test_access_port
bind tta_tlb_test tta_tlb_test_props u_props (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o));
